// file: tor_pkg.sv
// Constants and carrier types of the test and observation register page.
package tor_pkg;

    // Register offsets on the register port.
    localparam logic [5:0] TOR_OFF_SEL_ONE = 6'h31;
    localparam logic [5:0] TOR_OFF_SEL_TWO = 6'h32;
    localparam logic [5:0] TOR_OFF_LINE_GATE = 6'h33;
    localparam logic [5:0] TOR_OFF_OBS_VIEW = 6'h35;
    localparam logic [5:0] TOR_OFF_SELF_CHECK = 6'h36;
    localparam logic [5:0] TOR_OFF_VERSION = 6'h37;
    localparam logic [5:0] TOR_OFF_AUX_SEL = 6'h38;
    localparam logic [5:0] TOR_OFF_PROBE_ONE = 6'h39;
    localparam logic [5:0] TOR_OFF_PROBE_TWO = 6'h3A;
    localparam logic [5:0] TOR_OFF_ADC_VIEW = 6'h3B;
    localparam logic [5:0] TOR_OFF_PROD_A = 6'h3C;
    localparam logic [5:0] TOR_OFF_PROD_B = 6'h3D;
    localparam logic [5:0] TOR_OFF_PROD_C = 6'h3E;
    localparam logic [5:0] TOR_OFF_PROD_D = 6'h3F;

    // Reset values.
    localparam logic [7:0] TOR_RST_SEL_ONE = 8'h00;
    localparam logic [7:0] TOR_RST_SEL_TWO = 8'h00;
    localparam logic [7:0] TOR_RST_LINE_GATE = 8'h80;
    localparam logic [7:0] TOR_RST_SELF_CHECK = 8'h40;
    localparam logic [7:0] TOR_RST_AUX_SEL = 8'h00;
    localparam logic [7:0] TOR_RST_PROBE = 8'h00;
    localparam logic [7:0] TOR_RST_PROD_A = 8'hFF;
    localparam logic [7:0] TOR_RST_PROD_B = 8'h00;
    localparam logic [7:0] TOR_RST_PROD_C = 8'h03;
    localparam logic [7:0] TOR_RST_PROD_D = 8'h00;

    // Field positions.
    localparam int TOR_CLK_SRC_LSB = 4;
    localparam int TOR_CLK_PIN_BIT = 3;
    localparam int TOR_PRBS9_BIT = 6;
    localparam int TOR_PRBS15_BIT = 5;
    localparam int TOR_LINE_EN_BIT = 7;
    localparam int TOR_NONLIN_BIT = 6;
    localparam int TOR_AUX_ONE_LSB = 4;

    // Module clock sources.
    localparam logic [1:0] TOR_CLK_OFF = 2'h0;
    localparam logic [1:0] TOR_CLK_OSC = 2'h1;
    localparam logic [1:0] TOR_CLK_SERIAL = 2'h2;
    localparam logic [1:0] TOR_CLK_RF = 2'h3;

    // Self test and auxiliary pin codes.
    localparam logic [3:0] TOR_SELF_ON = 4'h9;
    localparam logic [3:0] TOR_AUX_TRI = 4'h0;
    localparam logic [3:0] TOR_AUX_PROBE = 4'h1;
    localparam logic [3:0] TOR_AUX_CLK = 4'h9;
    localparam logic [3:0] TOR_AUX_HIGH = 4'hA;
    localparam logic [3:0] TOR_AUX_LOW = 4'hB;
    localparam logic [3:0] TOR_AUX_TX = 4'hC;
    localparam logic [3:0] TOR_AUX_RX = 4'hD;
    localparam logic [3:0] TOR_AUX_SUB = 4'hE;
    localparam logic [3:0] TOR_AUX_OBS = 4'hF;

    // Sequence generator seeds.
    localparam logic [8:0] TOR_PRBS9_SEED = 9'h1FF;
    localparam logic [14:0] TOR_PRBS15_SEED = 15'h7FFF;

    // Register port request.
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tor_bus_req_type;

    // Pin drive: level and active-low output enable.
    typedef struct packed {
        logic level;
        logic oe_n;
    } tor_pin_type;

    // Sequence generator state.
    typedef enum logic [1:0] {
        TOR_SEQ_IDLE,
        TOR_SEQ_ARMED,
        TOR_SEQ_SEND
    } tor_seq_type;

endpackage

// file: tor_page.sv
// Test and observation register page with probe pin routing.
//
// What this block does
// - Two-bit code picks module clock: off, oscillator, serial clock, RF clock.
// - Clock-to-pin bit drives the module clock onto spare address pin five.
// - Three-bit selector picks observation bus bit for the observe pin.
// - PRBS9 enable bit feeds a nine-stage sequence after a send command.
// - PRBS15 enable bit feeds a fifteen-stage sequence after a send command.
// - Five-bit group select drives observation bus; its view reads live.
// - Clearing line enable disables both serial sideband lines; resets to 80h.
// - Self test field 1001 arms self test, run by checksum command.
// - Read-only version register at 37h returns a fixed code.
// - Aux codes: 0000 tristate, 0001 probe, 1001 clock, 1010 high, 1011 low.
// - Aux code 1100 outputs the transmit window flag.
// - Aux code 1101 outputs the receive window flag.
// - Aux code 1110 outputs the subcarrier detected flag.
// - Aux code 1111 outputs the selected observation bus bit.
// - Probe converter one holds six bits, routed to aux one on 0001.
// - Probe converter two holds six bits, routed to aux two on 0001.
// - ADC view returns in-phase nibble high, quadrature nibble low.
// - Production registers reset to FFh, 00h, 03h, 00h and stay untouched.
// - Nonlinear receiver bit at bit 6, set after reset.
`timescale 1ns/1ps
module tor_page #(
    parameter int GROUPS = 32,
    // Arbitrary neutral value.
    parameter logic [7:0] VERSION_CODE = 8'h5A
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire tor_pkg::tor_bus_req_type bus_req_i,
    output logic [7:0] rdata_o,
    input wire logic osc_clk_i,
    input wire logic serial_clk_i,
    input wire logic rf_clk_i,
    input wire logic [GROUPS*8-1:0] observe_groups_i,
    input wire logic [3:0] adc_i_sample_i,
    input wire logic [3:0] adc_q_sample_i,
    input wire logic transmit_window_flag_i,
    input wire logic receive_window_flag_i,
    input wire logic subcarrier_flag_i,
    input wire logic serial_aux_data_i,
    input wire logic serial_request_data_i,
    input wire logic send_command_i,
    input wire logic checksum_compute_command_i,
    output logic module_clock_o,
    output tor_pkg::tor_pin_type spare_address_pin_five_o,
    output logic signal_observe_pin_o,
    output tor_pkg::tor_pin_type serial_aux_output_o,
    output tor_pkg::tor_pin_type serial_request_output_o,
    output tor_pkg::tor_pin_type first_probe_pin_o,
    output tor_pkg::tor_pin_type second_probe_pin_o,
    output logic [1:0] probe_route_o,
    output logic [3:0] first_aux_selector_o,
    output logic [3:0] second_aux_selector_o,
    output logic [5:0] probe_converter_one_value_o,
    output logic [5:0] probe_converter_two_value_o,
    output logic prbs_valid_o,
    output logic prbs_data_o,
    output logic self_test_start_o,
    output logic receiver_nonlinear_bit_o
);

    logic [7:0] sel_one_r;
    logic [7:0] sel_two_r;
    logic line_en_r;
    logic nonlin_r;
    logic [3:0] self_check_r;
    logic [7:0] aux_sel_r;
    logic [5:0] probe_one_r;
    logic [5:0] probe_two_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic module_clock_r;
    logic observe_bit_r;
    tor_pkg::tor_pin_type pin_five_r;
    tor_pkg::tor_pin_type aux_line_r;
    tor_pkg::tor_pin_type req_line_r;
    tor_pkg::tor_pin_type aux_pin_r [2];
    logic [1:0] probe_route_r;
    tor_pkg::tor_seq_type seq_r;
    tor_pkg::tor_seq_type seq_nxt;
    logic [8:0] prbs9_r;
    logic [14:0] prbs15_r;
    logic self_start_r;

    // Address decode.
    wire logic wr_sel_one = bus_req_i.wr &&
        bus_req_i.addr == tor_pkg::TOR_OFF_SEL_ONE;
    wire logic wr_sel_two = bus_req_i.wr &&
        bus_req_i.addr == tor_pkg::TOR_OFF_SEL_TWO;
    wire logic wr_line = bus_req_i.wr &&
        bus_req_i.addr == tor_pkg::TOR_OFF_LINE_GATE;
    wire logic wr_self = bus_req_i.wr &&
        bus_req_i.addr == tor_pkg::TOR_OFF_SELF_CHECK;
    wire logic wr_aux = bus_req_i.wr &&
        bus_req_i.addr == tor_pkg::TOR_OFF_AUX_SEL;
    wire logic wr_probe_one = bus_req_i.wr &&
        bus_req_i.addr == tor_pkg::TOR_OFF_PROBE_ONE;
    wire logic wr_probe_two = bus_req_i.wr &&
        bus_req_i.addr == tor_pkg::TOR_OFF_PROBE_TWO;

    // Field views.
    wire logic [1:0] clk_src = sel_one_r[tor_pkg::TOR_CLK_SRC_LSB +: 2];
    wire logic clk_to_pin = sel_one_r[tor_pkg::TOR_CLK_PIN_BIT];
    wire logic [2:0] bit_sel = sel_one_r[2:0];
    wire logic [4:0] group_sel = sel_two_r[4:0];
    wire logic prbs9_en = sel_two_r[tor_pkg::TOR_PRBS9_BIT];
    wire logic prbs15_en = sel_two_r[tor_pkg::TOR_PRBS15_BIT];
    wire logic [3:0] aux_sel [2];
    assign aux_sel[0] = aux_sel_r[tor_pkg::TOR_AUX_ONE_LSB +: 4];
    assign aux_sel[1] = aux_sel_r[3:0];

    // Clock source selection; the sources are sampled as plain data.
    wire logic clk_sel = (clk_src == tor_pkg::TOR_CLK_OSC) ? osc_clk_i :
        (clk_src == tor_pkg::TOR_CLK_SERIAL) ? serial_clk_i :
        (clk_src == tor_pkg::TOR_CLK_RF) ? rf_clk_i : 1'b0;

    // Observation bus and its single bit. Out-of-range groups read zero.
    wire logic [7:0] observe_bus = (32'(group_sel) < GROUPS) ?
        observe_groups_i[8*group_sel +: 8] : 8'h00;
    wire logic observe_bit = observe_bus[bit_sel];

    // Read mux; observation views are combinational, so reads never
    // disturb the sampled logic.
    always_comb begin
        unique case (bus_req_i.addr)
            tor_pkg::TOR_OFF_SEL_ONE: rdata_nxt = sel_one_r;
            tor_pkg::TOR_OFF_SEL_TWO: rdata_nxt = sel_two_r;
            tor_pkg::TOR_OFF_LINE_GATE: rdata_nxt = {line_en_r, 7'h00};
            tor_pkg::TOR_OFF_OBS_VIEW: rdata_nxt = observe_bus;
            tor_pkg::TOR_OFF_SELF_CHECK: rdata_nxt = {1'b0, nonlin_r, 2'b00,
                self_check_r};
            tor_pkg::TOR_OFF_VERSION: rdata_nxt = VERSION_CODE;
            tor_pkg::TOR_OFF_AUX_SEL: rdata_nxt = aux_sel_r;
            tor_pkg::TOR_OFF_PROBE_ONE: rdata_nxt = {2'b00, probe_one_r};
            tor_pkg::TOR_OFF_PROBE_TWO: rdata_nxt = {2'b00, probe_two_r};
            tor_pkg::TOR_OFF_ADC_VIEW: rdata_nxt = {adc_i_sample_i,
                adc_q_sample_i};
            tor_pkg::TOR_OFF_PROD_A: rdata_nxt = tor_pkg::TOR_RST_PROD_A;
            tor_pkg::TOR_OFF_PROD_B: rdata_nxt = tor_pkg::TOR_RST_PROD_B;
            tor_pkg::TOR_OFF_PROD_C: rdata_nxt = tor_pkg::TOR_RST_PROD_C;
            tor_pkg::TOR_OFF_PROD_D: rdata_nxt = tor_pkg::TOR_RST_PROD_D;
            default: rdata_nxt = 8'h00;
        endcase
        if (!bus_req_i.rd) begin
            rdata_nxt = 8'h00;
        end
    end

    // Software registers. Production registers ignore writes.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sel_one_r <= tor_pkg::TOR_RST_SEL_ONE;
            sel_two_r <= tor_pkg::TOR_RST_SEL_TWO;
            line_en_r <= tor_pkg::TOR_RST_LINE_GATE[tor_pkg::TOR_LINE_EN_BIT];
            nonlin_r <= tor_pkg::TOR_RST_SELF_CHECK[tor_pkg::TOR_NONLIN_BIT];
            self_check_r <= tor_pkg::TOR_RST_SELF_CHECK[3:0];
            aux_sel_r <= tor_pkg::TOR_RST_AUX_SEL;
            probe_one_r <= tor_pkg::TOR_RST_PROBE[5:0];
            probe_two_r <= tor_pkg::TOR_RST_PROBE[5:0];
        end else begin
            if (wr_sel_one) begin
                sel_one_r <= bus_req_i.wdata;
            end
            if (wr_sel_two) begin
                // The fixed-zero bit is not stored.
                sel_two_r <= {1'b0, bus_req_i.wdata[6:0]};
            end
            if (wr_line) begin
                line_en_r <= bus_req_i.wdata[tor_pkg::TOR_LINE_EN_BIT];
            end
            if (wr_self) begin
                nonlin_r <= bus_req_i.wdata[tor_pkg::TOR_NONLIN_BIT];
                self_check_r <= bus_req_i.wdata[3:0];
            end
            if (wr_aux) begin
                aux_sel_r <= bus_req_i.wdata;
            end
            if (wr_probe_one) begin
                probe_one_r <= bus_req_i.wdata[5:0];
            end
            if (wr_probe_two) begin
                probe_two_r <= bus_req_i.wdata[5:0];
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Pin drive registers. Every pin is registered so that glitches from
    // the source muxes never reach the package.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            module_clock_r <= 1'b0;
            observe_bit_r <= 1'b0;
            pin_five_r <= '{level: 1'b0, oe_n: 1'b1};
            aux_line_r <= '{level: 1'b0, oe_n: 1'b1};
            req_line_r <= '{level: 1'b0, oe_n: 1'b1};
        end else begin
            module_clock_r <= clk_sel;
            observe_bit_r <= observe_bit;
            pin_five_r <= '{level: clk_sel, oe_n: !clk_to_pin};
            aux_line_r <= '{level: serial_aux_data_i, oe_n: !line_en_r};
            req_line_r <= '{level: serial_request_data_i,
                oe_n: !line_en_r};
        end
    end

    // Auxiliary pins share one decoder. Analog test codes, the probe converter
    // code among them, leave the digital driver off.
    for (genvar p = 0; p < 2; p++) begin : g_aux
        tor_pkg::tor_pin_type drive;
        always_comb begin
            drive = '{level: 1'b0, oe_n: 1'b0};
            unique case (aux_sel[p])
                tor_pkg::TOR_AUX_CLK: drive.level = clk_sel;
                tor_pkg::TOR_AUX_HIGH: drive.level = 1'b1;
                tor_pkg::TOR_AUX_LOW: drive.level = 1'b0;
                tor_pkg::TOR_AUX_TX: drive.level = transmit_window_flag_i;
                tor_pkg::TOR_AUX_RX: drive.level = receive_window_flag_i;
                tor_pkg::TOR_AUX_SUB: drive.level = subcarrier_flag_i;
                tor_pkg::TOR_AUX_OBS: drive.level = observe_bit;
                default: drive.oe_n = 1'b1;
            endcase
        end
        always_ff @(posedge clock_i or posedge rst_i) begin
            if (rst_i) begin
                aux_pin_r[p] <= '{level: 1'b0, oe_n: 1'b1};
                probe_route_r[p] <= 1'b0;
            end else begin
                aux_pin_r[p] <= drive;
                probe_route_r[p] <= aux_sel[p] == tor_pkg::TOR_AUX_PROBE;
            end
        end
    end

    // Sequence generator: armed while an enable is set, sending after the
    // send command. The nine-stage sequence wins if both are set.
    always_comb begin
        seq_nxt = seq_r;
        unique case (seq_r)
            tor_pkg::TOR_SEQ_IDLE: begin
                if (prbs9_en || prbs15_en) begin
                    seq_nxt = tor_pkg::TOR_SEQ_ARMED;
                end
            end
            tor_pkg::TOR_SEQ_ARMED: begin
                if (!(prbs9_en || prbs15_en)) begin
                    seq_nxt = tor_pkg::TOR_SEQ_IDLE;
                end else if (send_command_i) begin
                    seq_nxt = tor_pkg::TOR_SEQ_SEND;
                end
            end
            tor_pkg::TOR_SEQ_SEND: begin
                if (!(prbs9_en || prbs15_en)) begin
                    seq_nxt = tor_pkg::TOR_SEQ_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            seq_r <= tor_pkg::TOR_SEQ_IDLE;
            prbs9_r <= tor_pkg::TOR_PRBS9_SEED;
            prbs15_r <= tor_pkg::TOR_PRBS15_SEED;
        end else begin
            seq_r <= seq_nxt;
            if (seq_r == tor_pkg::TOR_SEQ_SEND) begin
                prbs9_r <= {prbs9_r[7:0], prbs9_r[8] ^ prbs9_r[4]};
                prbs15_r <= {prbs15_r[13:0],
                    prbs15_r[14] ^ prbs15_r[13]};
            end else begin
                prbs9_r <= tor_pkg::TOR_PRBS9_SEED;
                prbs15_r <= tor_pkg::TOR_PRBS15_SEED;
            end
        end
    end

    // Self test start pulse.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            self_start_r <= 1'b0;
        end else begin
            self_start_r <= checksum_compute_command_i &&
                self_check_r == tor_pkg::TOR_SELF_ON;
        end
    end

    assign rdata_o = rdata_r;
    assign module_clock_o = module_clock_r;
    assign spare_address_pin_five_o = pin_five_r;
    assign signal_observe_pin_o = observe_bit_r;
    assign serial_aux_output_o = aux_line_r;
    assign serial_request_output_o = req_line_r;
    assign first_probe_pin_o = aux_pin_r[0];
    assign second_probe_pin_o = aux_pin_r[1];
    assign probe_route_o = probe_route_r;
    assign first_aux_selector_o = aux_sel[0];
    assign second_aux_selector_o = aux_sel[1];
    assign probe_converter_one_value_o = probe_one_r;
    assign probe_converter_two_value_o = probe_two_r;
    assign prbs_valid_o = seq_r == tor_pkg::TOR_SEQ_SEND;
    assign prbs_data_o = prbs9_en ? prbs9_r[8] : prbs15_r[14];
    assign self_test_start_o = self_start_r;
    assign receiver_nonlinear_bit_o = nonlin_r;

    // Checks.
    AST_CLK_OFF: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_src == tor_pkg::TOR_CLK_OFF |=> !module_clock_o)
        else $error("module clock not off for source code zero");
    AST_PIN_FIVE: assert property (@(posedge clock_i) disable iff (rst_i)
        !clk_to_pin |=> spare_address_pin_five_o.oe_n)
        else $error("pin five driven while clock-to-pin clear");
    AST_OBS_BIT: assert property (@(posedge clock_i) disable iff (rst_i)
        1'b1 |=> signal_observe_pin_o == $past(observe_bit))
        else $error("observe pin does not follow selected bit");
    AST_SEQ_WAIT: assert property (@(posedge clock_i) disable iff (rst_i)
        seq_r == tor_pkg::TOR_SEQ_ARMED && !send_command_i |=> !prbs_valid_o)
        else $error("sequence started without send command");
    AST_SEQ_GO: assert property (@(posedge clock_i) disable iff (rst_i)
        seq_r == tor_pkg::TOR_SEQ_ARMED && send_command_i &&
        (prbs9_en || prbs15_en) ##1 (prbs9_en || prbs15_en) |-> prbs_valid_o)
        else $error("sequence not sending after send command");
    AST_OBS_READ: assert property (@(posedge clock_i) disable iff (rst_i)
        bus_req_i.rd && bus_req_i.addr == tor_pkg::TOR_OFF_OBS_VIEW |=>
        rdata_o == $past(observe_bus))
        else $error("observation view not live");
    AST_LINE_GATE: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_line && !bus_req_i.wdata[7] |=> ##1
        serial_aux_output_o.oe_n && serial_request_output_o.oe_n)
        else $error("sideband lines not disabled");
    AST_SELF: assert property (@(posedge clock_i) disable iff (rst_i)
        checksum_compute_command_i && self_check_r != tor_pkg::TOR_SELF_ON
        |=> !self_test_start_o)
        else $error("self test started while not armed");
    AST_VERSION: assert property (@(posedge clock_i) disable iff (rst_i)
        bus_req_i.rd && bus_req_i.addr == tor_pkg::TOR_OFF_VERSION |=>
        rdata_o == VERSION_CODE)
        else $error("version read wrong");
    AST_AUX_TRI: assert property (@(posedge clock_i) disable iff (rst_i)
        aux_sel[0] == tor_pkg::TOR_AUX_TRI |=> first_probe_pin_o.oe_n)
        else $error("aux one driven while tristated");
    AST_AUX_TX: assert property (@(posedge clock_i) disable iff (rst_i)
        aux_sel[1] == tor_pkg::TOR_AUX_TX |=> !second_probe_pin_o.oe_n &&
        second_probe_pin_o.level == $past(transmit_window_flag_i))
        else $error("aux two not showing transmit window");
    AST_ADC: assert property (@(posedge clock_i) disable iff (rst_i)
        bus_req_i.rd && bus_req_i.addr == tor_pkg::TOR_OFF_ADC_VIEW |=>
        rdata_o == {$past(adc_i_sample_i), $past(adc_q_sample_i)})
        else $error("adc view nibbles wrong");
    AST_PROD_C: assert property (@(posedge clock_i) disable iff (rst_i)
        bus_req_i.rd && bus_req_i.addr == tor_pkg::TOR_OFF_PROD_C |=>
        rdata_o == 8'h03)
        else $error("production register value changed");
    COV_SEND: cover property (@(posedge clock_i) disable iff (rst_i)
        seq_r == tor_pkg::TOR_SEQ_ARMED ##1 prbs_valid_o);
    COV_SELF: cover property (@(posedge clock_i) disable iff (rst_i)
        self_test_start_o);
    COV_AUX_OBS: cover property (@(posedge clock_i) disable iff (rst_i)
        aux_sel[0] == tor_pkg::TOR_AUX_OBS && observe_bit);

endmodule

// file: tor_page_tb.sv
// Self-checking testbench of the test and observation register page.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tor_page_tb;
    localparam logic [7:0] VER = 8'h5A; // Arbitrary version code.
    logic clock_i, rst_i, osc, ser, rf, txf, rxf, subf, auxd, reqd, send, crc;
    tor_pkg::tor_bus_req_type req;
    logic [7:0] rdata;
    logic [255:0] groups;
    logic [3:0] adc_i, adc_q;
    logic mclk, obs, pv, st, nl, pd;
    logic [3:0] s1, s2;
    tor_pkg::tor_pin_type pin5, sa, sr, p1, p2;
    logic [1:0] route;
    logic [5:0] dac1, dac2;
    int miscompares, checked;
    tor_page #(.VERSION_CODE(VER)) uut (.clock_i(clock_i), .rst_i(rst_i),
        .bus_req_i(req), .rdata_o(rdata), .osc_clk_i(osc),
        .serial_clk_i(ser), .rf_clk_i(rf), .observe_groups_i(groups),
        .adc_i_sample_i(adc_i), .adc_q_sample_i(adc_q),
        .transmit_window_flag_i(txf), .receive_window_flag_i(rxf),
        .subcarrier_flag_i(subf), .serial_aux_data_i(auxd),
        .serial_request_data_i(reqd), .send_command_i(send),
        .checksum_compute_command_i(crc), .module_clock_o(mclk),
        .spare_address_pin_five_o(pin5), .signal_observe_pin_o(obs),
        .serial_aux_output_o(sa), .serial_request_output_o(sr),
        .first_probe_pin_o(p1), .second_probe_pin_o(p2),
        .probe_route_o(route), .first_aux_selector_o(s1),
        .second_aux_selector_o(s2), .probe_converter_one_value_o(dac1),
        .probe_converter_two_value_o(dac2), .prbs_valid_o(pv),
        .prbs_data_o(pd), .self_test_start_o(st),
        .receiver_nonlinear_bit_o(nl));
    initial begin
        clock_i = 0;
        forever #2 clock_i = ~clock_i;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock_i) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock_i) req.wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
        @(posedge clock_i) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock_i) req.rd <= 1'b0;
        #1 `CHK("rdata", e, rdata)
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic pulse_crc();
        @(posedge clock_i) crc <= 1'b1;
        @(posedge clock_i) crc <= 1'b0;
        #1;
    endtask
    task automatic t_reset();
        rdchk(6'h33, 8'h80);
        `CHK("line oe", 1'b0, sa.oe_n)
        rdchk(6'h36, 8'h40);
        wr(6'h37, 8'h00);
        rdchk(6'h37, VER);
        wr(6'h3C, 8'h00);
        rdchk(6'h3C, 8'hFF);
        rdchk(6'h3D, 8'h00);
        rdchk(6'h3E, 8'h03);
        rdchk(6'h3F, 8'h00);
        rdchk(6'h10, 8'h00);
    endtask
    task automatic t_clock();
        for (int c = 0; c < 4; c++) begin
            for (int v = 0; v < 2; v++) begin
                wr(6'h31, {2'b00, 2'(c), 4'h8});
                osc <= (c == 1) ? 1'(v) : ~1'(v);
                ser <= (c == 2) ? 1'(v) : ~1'(v);
                rf <= (c == 3) ? 1'(v) : ~1'(v);
                tick(3);
                `CHK("mclk", (c == 0) ? 1'b0 : 1'(v), mclk)
                `CHK("pin5", {c != 0 && v != 0, 1'b0}, pin5)
            end
        end
        wr(6'h31, 8'h00);
        tick(3);
        `CHK("pin5 oe", 1'b1, pin5.oe_n)
    endtask
    task automatic t_observe(input int g, input int b);
        logic [7:0] e;
        e = groups[8*g+:8];
        wr(6'h32, 8'(g));
        wr(6'h31, 8'(b));
        wr(6'h38, 8'hF0);
        tick(3);
        rdchk(6'h35, e);
        `CHK("obs", e[b], obs)
        `CHK("aux obs", {e[b], 1'b0}, p1)
        @(posedge clock_i) groups[8*g+:8] <= ~e;
        tick(2);
        rdchk(6'h35, ~e);
    endtask
    task automatic t_lines();
        wr(6'h33, 8'h00);
        tick(3);
        `CHK("line off", 2'b11, {sa.oe_n, sr.oe_n})
        wr(6'h33, 8'h80);
        tick(3);
        `CHK("line on", 4'b1000, {sa, sr})
    endtask
    task automatic t_aux();
        logic [3:0] cd[7] = '{4'h0, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'h9};
        logic [6:0] lv = 7'h2A;
        for (int i = 0; i < 7; i++) begin
            wr(6'h38, {cd[i], cd[i]});
            tick(3);
            `CHK("aux sel", {cd[i], cd[i]}, {s1, s2})
            `CHK("aux oe", {2{i == 0}}, {p1.oe_n, p2.oe_n})
            if (i > 0) begin
                `CHK("aux", {2{lv[i]}}, {p1[1], p2[1]})
            end
        end
        wr(6'h38, 8'h10);
        tick(2);
        `CHK("route", 2'b01, route)
        wr(6'h38, 8'h01);
        wr(6'h39, 8'hFF);
        wr(6'h3A, 8'h2A);
        tick(2);
        `CHK("route", 2'b10, route)
        `CHK("dac", 12'hFEA, {dac1, dac2})
    endtask
    task automatic t_prbs(input logic [7:0] en);
        logic [14:0] m;
        m = 15'h7FFF;
        wr(6'h32, en);
        tick(3);
        `CHK("prbs idle", 1'b0, pv)
        @(posedge clock_i) send <= 1'b1;
        @(posedge clock_i) send <= 1'b0;
        // Reference generators: x^9 + x^5 + 1 and x^15 + x^14 + 1.
        for (int k = 0; k < 24; k++) begin
            #1 `CHK("prbs bit", en[6] ? m[8] : m[14], pd)
            m = en[6] ? {m[13:0], m[8] ^ m[4]} : {m[13:0], m[14] ^ m[13]};
            @(posedge clock_i);
        end
        #1 `CHK("prbs on", 1'b1, pv)
        wr(6'h32, 8'h00);
        tick(2);
        `CHK("prbs off", 1'b0, pv)
    endtask
    task automatic t_self();
        wr(6'h36, 8'h49);
        pulse_crc();
        `CHK("start", 1'b1, st)
        tick(1);
        `CHK("start end", 1'b0, st)
        `CHK("nonlin", 1'b1, nl)
        wr(6'h36, 8'h00);
        pulse_crc();
        `CHK("no start", 2'b00, {st, nl})
        @(posedge clock_i);
        adc_i <= 4'hA;
        adc_q <= 4'h3;
        rdchk(6'h3B, 8'hA3);
    endtask
    task automatic conclude();
        if (miscompares == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        miscompares++;
        conclude();
    end
    initial begin
        miscompares = 0;
        checked = 0;
        rst_i = 1;
        req = '0;
        {osc, ser, rf, send, crc, auxd, reqd} = 7'h00;
        {txf, rxf, subf} = 3'b101;
        adc_i = 4'h0;
        adc_q = 4'h0;
        for (int g = 0; g < 32; g++) groups[8*g+:8] = 8'(g * 7 + 17);
        repeat (12) @(posedge clock_i);
        rst_i <= 0;
        auxd <= 1'b1;
        t_reset();
        t_clock();
        t_observe(5, 2);
        t_observe(31, 7);
        t_lines();
        t_aux();
        t_prbs(8'h40);
        t_prbs(8'h20);
        t_self();
        conclude();
    end
endmodule
